/* File: src/cim_regs.v */
// channel input selection and map checksum register bank, top level
// Overview of operation
// - channel 1 selector picks pins, short, test
// - channel 2 register at 13h, resets zero
// - channel 2 selector picks pins, short, test
// - code 01b opens pins, shorts converter inputs
// - channel 3 register at 18h, resets zero
// - channel 3 selector picks pins, short, test
// - checksum register at 3Eh, read-only, resets zero
// - checksum shows map value from four clocks after the last channel write, ignores writes
`timescale 1ns/1ps
`default_nettype none
`include "cim_consts.vh"

module cim_regs #(
	parameter BBM_CYCLES = `CIM_BBM_CYCLES,
	parameter CNT_W      = 4
) (
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        reset_n_i,
	// register access from the serial port logic
	input  wire  [5:0] reg_addr_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	input  wire [15:0] reg_wdata_i,
	output reg  [15:0] reg_rdata_o,
	output reg         reg_rvalid_o,
	output reg         reg_err_o,
	// input switches, bit 0 is channel 1, bit 2 is channel 3
	output wire  [2:0] pin_connect_o,
	output wire  [2:0] inputs_short_o,
	output wire  [2:0] test_pos_o,
	output wire  [2:0] test_neg_o,
	output wire  [2:0] switch_settling_o,
	// checksum state
	output wire        checksum_busy_o
);

	wire        hit_ch1;
	wire        hit_ch2;
	wire        hit_ch3;
	wire        hit_crc;
	wire        any_hit;
	wire        ch_write;
	wire [15:0] cfg1;
	wire [15:0] cfg2;
	wire [15:0] cfg3;
	wire [15:0] crc;
	reg  [15:0] next_rdata;

	assign hit_ch1  = (reg_addr_i == `CIM_CHAN1_CFG_ADDR);
	assign hit_ch2  = (reg_addr_i == `CIM_CHAN2_CFG_ADDR);
	assign hit_ch3  = (reg_addr_i == `CIM_CHAN3_CFG_ADDR);
	assign hit_crc  = (reg_addr_i == `CIM_MAP_CHECKSUM_ADDR);
	assign any_hit  = hit_ch1 | hit_ch2 | hit_ch3 | hit_crc;
	assign ch_write = reg_wr_i & (hit_ch1 | hit_ch2 | hit_ch3);

	cim_chan_cfg #(
		.BBM_CYCLES (BBM_CYCLES),
		.CNT_W      (CNT_W)
	) u_ch1 (
		.sys_clk_i  (sys_clk_i),
		.reset_n_i  (reset_n_i),
		.wr_i       (reg_wr_i & hit_ch1),
		.wdata_i    (reg_wdata_i),
		.cfg_o      (cfg1),
		.connect_o  (pin_connect_o[0]),
		.short_o    (inputs_short_o[0]),
		.test_pos_o (test_pos_o[0]),
		.test_neg_o (test_neg_o[0]),
		.settling_o (switch_settling_o[0])
	);

	cim_chan_cfg #(
		.BBM_CYCLES (BBM_CYCLES),
		.CNT_W      (CNT_W)
	) u_ch2 (
		.sys_clk_i  (sys_clk_i),
		.reset_n_i  (reset_n_i),
		.wr_i       (reg_wr_i & hit_ch2),
		.wdata_i    (reg_wdata_i),
		.cfg_o      (cfg2),
		.connect_o  (pin_connect_o[1]),
		.short_o    (inputs_short_o[1]),
		.test_pos_o (test_pos_o[1]),
		.test_neg_o (test_neg_o[1]),
		.settling_o (switch_settling_o[1])
	);

	cim_chan_cfg #(
		.BBM_CYCLES (BBM_CYCLES),
		.CNT_W      (CNT_W)
	) u_ch3 (
		.sys_clk_i  (sys_clk_i),
		.reset_n_i  (reset_n_i),
		.wr_i       (reg_wr_i & hit_ch3),
		.wdata_i    (reg_wdata_i),
		.cfg_o      (cfg3),
		.connect_o  (pin_connect_o[2]),
		.short_o    (inputs_short_o[2]),
		.test_pos_o (test_pos_o[2]),
		.test_neg_o (test_neg_o[2]),
		.settling_o (switch_settling_o[2])
	);

	// writes to the checksum address reach no storage
	cim_checksum u_crc (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.restart_i (ch_write),
		.word0_i   (cfg1),
		.word1_i   (cfg2),
		.word2_i   (cfg3),
		.crc_o     (crc),
		.busy_o    (checksum_busy_o)
	);

	always @* begin
		next_rdata = `CIM_READ_ZERO;
		if (hit_ch1) begin
			next_rdata = cfg1;
		end else if (hit_ch2) begin
			next_rdata = cfg2;
		end else if (hit_ch3) begin
			next_rdata = cfg3;
		end else if (hit_crc) begin
			next_rdata = crc;
		end
	end

	// a read shows the value held before a write in the same cycle
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o  <= `CIM_READ_ZERO;
			reg_rvalid_o <= 1'b0;
			reg_err_o    <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
			reg_err_o <= ((reg_rd_i | reg_wr_i) & ~any_hit) |
				(reg_wr_i & hit_crc);
		end
	end

endmodule
`default_nettype wire

/* File: src/cim_consts.vh */
// constants for the channel input mux and map checksum register bank
`ifndef CIM_CONSTS_VH
`define CIM_CONSTS_VH

`define CIM_ADDR_W           6
`define CIM_DATA_W           16

`define CIM_CHAN1_CFG_ADDR   6'h0E
`define CIM_CHAN2_CFG_ADDR   6'h13
`define CIM_CHAN3_CFG_ADDR   6'h18
`define CIM_MAP_CHECKSUM_ADDR 6'h3E

`define CIM_CHAN_CFG_RESET   16'h0000
`define CIM_MAP_CHECKSUM_RESET 16'h0000
`define CIM_READ_ZERO        16'h0000

`define CIM_SEL_LSB          0
`define CIM_SEL_MSB          1
`define CIM_RSVD_RO_LSB      3
`define CIM_RSVD_RO_MSB      5
`define CIM_CHAN_WR_MASK     16'hFFC7

`define CIM_SEL_PINS         2'h0
`define CIM_SEL_SHORT        2'h1
`define CIM_SEL_TEST_POS     2'h2
`define CIM_SEL_TEST_NEG     2'h3

`define CIM_CRC_POLY         16'h1021
`define CIM_CRC_SEED         16'h0000

`define CIM_CLK_PERIOD_NS    4
`define CIM_BBM_TIME_NS      20
`define CIM_BBM_CYCLES \
	((`CIM_BBM_TIME_NS + `CIM_CLK_PERIOD_NS - 1) / `CIM_CLK_PERIOD_NS)

`endif

/* File: src/cim_chan_cfg.v */
// one channel configuration register with its input switch sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cim_consts.vh"

module cim_chan_cfg #(
	parameter BBM_CYCLES = `CIM_BBM_CYCLES,
	parameter CNT_W      = 4
) (
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        reset_n_i,
	// register access
	input  wire        wr_i,
	input  wire [15:0] wdata_i,
	output wire [15:0] cfg_o,
	// input switches
	output reg         connect_o,
	output reg         short_o,
	output reg         test_pos_o,
	output reg         test_neg_o,
	output reg         settling_o
);

	localparam ST_IDLE = 1'b0;
	localparam ST_OPEN = 1'b1;
	localparam integer     BBM_LAST_I = BBM_CYCLES - 1;
	localparam [CNT_W-1:0] BBM_LAST   = BBM_LAST_I[CNT_W-1:0];

	reg             [15:0] stored;
	reg              [1:0] applied_sel;
	reg                    state;
	reg        [CNT_W-1:0] cnt;
	wire             [1:0] sel;

	assign sel   = stored[`CIM_SEL_MSB:`CIM_SEL_LSB];
	assign cfg_o = stored; // reserved read-only bits never stored

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stored <= `CIM_CHAN_CFG_RESET;
		end else if (wr_i) begin
			stored <= wdata_i & `CIM_CHAN_WR_MASK;
		end
	end

	// all switches open for a while before a new path closes, so the
	// pins are never shorted to a test source during a change
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state       <= ST_IDLE;
			cnt         <= {CNT_W{1'b0}};
			applied_sel <= `CIM_SEL_PINS;
		end else begin
			case (state)
			ST_IDLE: begin
				if (sel != applied_sel) begin
					state <= ST_OPEN;
					cnt   <= {CNT_W{1'b0}};
				end
			end
			ST_OPEN: begin
				if (cnt == BBM_LAST) begin
					state       <= ST_IDLE;
					applied_sel <= sel;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			connect_o  <= 1'b1;
			short_o    <= 1'b0;
			test_pos_o <= 1'b0;
			test_neg_o <= 1'b0;
			settling_o <= 1'b0;
		end else begin
			settling_o <= (state == ST_OPEN) || (sel != applied_sel);
			if ((state == ST_OPEN) || (sel != applied_sel)) begin
				connect_o  <= 1'b0;
				short_o    <= 1'b0;
				test_pos_o <= 1'b0;
				test_neg_o <= 1'b0;
			end else begin
				connect_o  <= (applied_sel == `CIM_SEL_PINS);
				short_o    <= (applied_sel == `CIM_SEL_SHORT);
				test_pos_o <= (applied_sel == `CIM_SEL_TEST_POS);
				test_neg_o <= (applied_sel == `CIM_SEL_TEST_NEG);
			end
		end
	end

endmodule
`default_nettype wire

/* File: src/cim_checksum.v */
// checksum engine walking the channel configuration words
`timescale 1ns/1ps
`default_nettype none
`include "cim_consts.vh"

module cim_checksum (
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        reset_n_i,
	// map contents
	input  wire        restart_i,
	input  wire [15:0] word0_i,
	input  wire [15:0] word1_i,
	input  wire [15:0] word2_i,
	// result
	output reg  [15:0] crc_o,
	output reg         busy_o
);

	reg        pend;
	reg  [1:0] idx;
	reg [15:0] acc;
	reg [15:0] cur;

	function [15:0] crc_word;
		input [15:0] c;
		input [15:0] d;
		integer i;
		reg [15:0] r;
		begin
			r = c;
			for (i = 15; i >= 0; i = i - 1) begin
				if (r[15] ^ d[i]) begin
					r = {r[14:0], 1'b0} ^ `CIM_CRC_POLY;
				end else begin
					r = {r[14:0], 1'b0};
				end
			end
			crc_word = r;
		end
	endfunction

	always @* begin
		case (idx)
		2'h0:    cur = word0_i;
		2'h1:    cur = word1_i;
		default: cur = word2_i;
		endcase
	end

	// seed zero keeps an all-zero map consistent with the reset value
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pend   <= 1'b0;
			idx    <= 2'h0;
			acc    <= `CIM_CRC_SEED;
			crc_o  <= `CIM_MAP_CHECKSUM_RESET;
			busy_o <= 1'b0;
		end else begin
			if (pend) begin
				pend   <= restart_i;
				idx    <= 2'h0;
				acc    <= `CIM_CRC_SEED;
				busy_o <= 1'b1;
			end else begin
				pend <= restart_i;
				if (busy_o) begin
					acc <= crc_word(acc, cur);
					idx <= idx + 2'h1;
					if (idx == 2'h2) begin
						crc_o  <= crc_word(acc, cur);
						busy_o <= 1'b0;
					end
				end
			end
		end
	end

endmodule
`default_nettype wire

/* File: verif/cim_regs_monitor.sv */
// bound checker on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module cim_regs_monitor #(
	parameter BBM_CYCLES = 5
) (
	// clock, reset and requests
	input wire logic        sys_clk_i,
	input wire logic        reset_n_i,
	input wire logic  [5:0] reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	// answers and switches
	input wire logic [15:0] reg_rdata_o,
	input wire logic        reg_rvalid_o,
	input wire logic        reg_err_o,
	input wire logic  [2:0] pin_connect_o,
	input wire logic  [2:0] inputs_short_o,
	input wire logic  [2:0] test_pos_o,
	input wire logic  [2:0] test_neg_o,
	input wire logic  [2:0] switch_settling_o,
	input wire logic        checksum_busy_o
);
	// settling plus four cycles for the registered stages around it
	localparam int SET_MAX = BBM_CYCLES + 4;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	rsvd_zero_a: assert property (reg_rvalid_o
		&& $past(reg_addr_i) != 6'h3E |-> reg_rdata_o[5:3] == 3'h0)
		else $error("reserved bits not zero");
	sum_refuse_a: assert property (reg_wr_i
		&& reg_addr_i == 6'h3E |=> reg_err_o) else $error("sum write taken");
	short_opens_a: assert property (
		(inputs_short_o & pin_connect_o) == 3'h0) else $error("short with pins");
	one_source_a: assert property (((test_pos_o & test_neg_o)
		| (pin_connect_o & (test_pos_o | test_neg_o))) == 3'h0)
		else $error("two sources on one channel");
	settle_open_a: assert property ((switch_settling_o
		& (pin_connect_o | inputs_short_o | test_pos_o | test_neg_o)) == 3'h0)
		else $error("switch closed while settling");
	ch2_pos_a: assert property (reg_wr_i && reg_addr_i == 6'h13
		&& reg_wdata_i[1:0] == 2'h2 |=> ##[0:SET_MAX] test_pos_o[1])
		else $error("channel 2 test source late");
	sum_done_a: assert property ($rose(checksum_busy_o)
		|-> ##[1:40] !checksum_busy_o) else $error("checksum stuck busy");
endmodule
bind cim_regs cim_regs_monitor #(.BBM_CYCLES(BBM_CYCLES)) u_mon (.*);
`default_nettype wire

/* File: verif/cim_host_model.sv */
// host side model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module cim_host_model (
	// clock and answers
	input  wire logic        sys_clk_i,
	input  wire logic [15:0] reg_rdata_o,
	input  wire logic        reg_rvalid_o,
	input  wire logic        reg_err_o,
	// requests
	output var  logic  [5:0] reg_addr_i,
	output var  logic        reg_wr_i,
	output var  logic        reg_rd_i,
	output var  logic [15:0] reg_wdata_i
);
	initial begin
		reg_addr_i = 6'h3F;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_wdata_i = 16'hA5A5;
	end
	// one strobe cycle; answer is taken once the strobe edge has landed
	task automatic access(input logic w, input logic [5:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic e,
		output logic v);
		@(posedge sys_clk_i);
		#1;
		reg_addr_i = a;
		reg_wdata_i = d & 16'h003B;
		reg_wr_i = w;
		reg_rd_i = !w;
		@(posedge sys_clk_i);
		#1;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = ~a;
		reg_wdata_i = ~reg_wdata_i;
		q = reg_rdata_o;
		e = reg_err_o;
		v = reg_rvalid_o;
	endtask
endmodule
`default_nettype wire

/* File: verif/test_cim_regs.sv */
// self-checking bench for the channel input register bank
`timescale 1ns/1ps
`default_nettype none
module test_cim_regs;
	logic        sys_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic  [5:0] reg_addr_i;
	logic        reg_wr_i, reg_rd_i, reg_rvalid_o, reg_err_o, busy;
	logic [15:0] reg_wdata_i, reg_rdata_o, q, sum;
	logic  [2:0] conn, shrt, tpos, tneg, settle;
	logic        e, v;
	int          miscompares = 0;
	int          checks_done = 0;
	int          cycles = 0;
	logic  [5:0] chan_addr [4] = '{6'h0E, 6'h13, 6'h18, 6'h3E};
	always #2 sys_clk_i = ~sys_clk_i;
	cim_regs #(.BBM_CYCLES(2), .CNT_W(4)) u_dut (.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.reg_err_o(reg_err_o), .pin_connect_o(conn), .inputs_short_o(shrt),
		.test_pos_o(tpos), .test_neg_o(tneg), .switch_settling_o(settle),
		.checksum_busy_o(busy));
	cim_host_model u_host (.sys_clk_i(sys_clk_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .reg_err_o(reg_err_o),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i));
	task automatic check(input string name, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude;
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic logic [15:0] sum_step(logic [15:0] c, logic [15:0] d);
		for (int i = 15; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction
	// bounded wait for the switch sequencer and the checksum engine
	task automatic idle_wait;
		int n;
		n = 0;
		while ((settle !== 3'h0 || busy !== 1'b0) && n < 40) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
	endtask
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			miscompares++;
			conclude();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk_i);
		#1;
		reset_n_i = 1'b1;
		check("connect", {13'h0, conn}, 16'h0007);
		for (int k = 0; k < 4; k++) begin
			u_host.access(1'b0, chan_addr[k], 16'h0000, q, e, v);
			check("reset value", q, 16'h0000);
			check("rvalid", {15'h0, v}, 16'h0001);
		end
		for (int c = 0; c < 4; c++)
			for (int k = 0; k < 3; k++) begin
				u_host.access(1'b1, chan_addr[k], 16'h0038 | 16'(c), q, e, v);
				// sequencer and checksum engine react one edge after the write
				@(posedge sys_clk_i);
				#1;
				check("settling", {13'h0, settle},
					(c == 0) ? 16'h0000 : 16'h0001 << k);
				check("busy", {15'h0, busy}, 16'h0001);
				idle_wait();
				check("idle", {12'h0, busy, settle}, 16'h0000);
				u_host.access(1'b0, chan_addr[k], 16'h0000, q, e, v);
				check("readback", q, 16'(c));
				check("switches", {12'h0, conn[k], shrt[k], tpos[k], tneg[k]},
					16'h0008 >> c);
			end
		sum = sum_step(sum_step(sum_step(16'h0, 16'h3), 16'h3), 16'h3);
		u_host.access(1'b1, 6'h3E, 16'hFFFF, q, e, v);
		check("sum write err", {15'h0, e}, 16'h0001);
		u_host.access(1'b0, 6'h3E, 16'h0000, q, e, v);
		check("map sum", q, sum);
		u_host.access(1'b0, 6'h05, 16'h0000, q, e, v);
		check("unmapped", {q[14:0], e}, 16'h0001);
		conclude();
	end
endmodule
`default_nettype wire
